// >>> rtl/asr_dev.sv
// Converter end: conversion control and serial result readout.
// Assumes sck comes from the host; clk is the converter's own clock.
// Operation
// - Select high at start: chip-select, output released
// - Host holds start high through conversion, readback
// - Select and start both low: drive low
// - No-busy host brings select low after done
// - Done: acquisition phase, core powered down
// - Select low shows MSB, falls shift on
// - Four-wire no-busy releases after 16th fall
// - Data valid on both clock edges
// - Busy host holds select low through conversion
// - Busy: released output driven low at done
// - Busy four-wire releases after 17th fall
// - Select and clock low at start: chain, no busy
// - Chain no-busy: MSB out at done
// - Chain: select input shifts in on falls
// - Host gives sixteen clocks per device
// - Select low, clock high at start: chain with busy
// - Chain busy: output high when chain done
// - Host adds one clock to flush busy
// - Host holds start high in chain readback
// - Select high picks chip-select, else chain
// - Host activity only in first quarter
`default_nettype none

module asr_dev #(
  parameter int CONV_CYC = asr_pkg::CONV_MAX_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  asr_link_if.dev                       link,
  input  wire logic [asr_pkg::RES_W-1:0] sample_value,
  output logic                          conv_busy,
  output logic                          powered_down,
  output logic [asr_pkg::RES_W-1:0]     result
);

  localparam int CW = asr_pkg::CNT_W;
  localparam int RW = asr_pkg::RES_W;
  localparam logic [3:0] MSB_IDX = 4'(RW - 1);

  typedef enum logic [1:0] {
    ASR_IDLE,
    ASR_CONV,
    ASR_ACQ
  } asr_dev_state_t;

  // Link-clock domain: count falls and capture the chain input
  logic [CW-1:0] fall_bin_reg;
  logic [CW-1:0] fall_gray_reg;
  logic [RW-1:0] chain_sr_reg;
  logic [CW-1:0] fall_bin_next;

  assign fall_bin_next = fall_bin_reg + 1'b1;

  always_ff @(negedge link.sck or negedge rstn) begin
    if (!rstn) begin
      fall_bin_reg  <= '0;
      fall_gray_reg <= '0;
    end else begin
      fall_bin_reg  <= fall_bin_next;
      fall_gray_reg <= asr_pkg::bin2gray(fall_bin_next);
    end
  end

  always_ff @(negedge link.sck or negedge rstn) begin
    if (!rstn) begin
      chain_sr_reg <= '0;
    end else begin
      chain_sr_reg <= {chain_sr_reg[RW-2:0], link.select_or_chain_input};
    end
  end

  // Crossings into the converter clock
  logic          cnv_s1, cnv_s2, cnv_q;
  logic          sdi_s1, sdi_s2, sdi_q;
  logic          sck_s1, sck_s2;
  logic          chn_s1, chn_s2;
  logic [CW-1:0] gray_s1, gray_s2;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnv_s1  <= 1'b0;
      cnv_s2  <= 1'b0;
      cnv_q   <= 1'b0;
      sdi_s1  <= 1'b0;
      sdi_s2  <= 1'b0;
      sdi_q   <= 1'b0;
      sck_s1  <= 1'b0;
      sck_s2  <= 1'b0;
      chn_s1  <= 1'b0;
      chn_s2  <= 1'b0;
      gray_s1 <= '0;
      gray_s2 <= '0;
    end else begin
      cnv_s1  <= link.conversion_start;
      cnv_s2  <= cnv_s1;
      cnv_q   <= cnv_s2;
      sdi_s1  <= link.select_or_chain_input;
      sdi_s2  <= sdi_s1;
      sdi_q   <= sdi_s2;
      sck_s1  <= link.sck;
      sck_s2  <= sck_s1;
      chn_s1  <= chain_sr_reg[RW-1];
      chn_s2  <= chn_s1;
      gray_s1 <= fall_gray_reg;
      gray_s2 <= gray_s1;
    end
  end

  logic          cnv_rise, cnv_fall, sdi_fall;
  logic [CW-1:0] fall_now;

  assign cnv_rise = cnv_s2 && !cnv_q;
  assign cnv_fall = !cnv_s2 && cnv_q;
  assign sdi_fall = !sdi_s2 && sdi_q;
  assign fall_now = asr_pkg::gray2bin(gray_s2);

  // Conversion control
  asr_dev_state_t state_reg;
  logic [7:0]     conv_cnt_reg;
  logic           cs_mode_reg;
  logic           chain_busy_reg;
  logic           busy_en_reg;
  logic [RW-1:0]  sample_reg;
  logic [RW-1:0]  result_reg;
  logic [CW-1:0]  base_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= ASR_IDLE;
      conv_cnt_reg <= '0;
    end else begin
      case (state_reg)
        ASR_IDLE: begin
          if (cnv_rise) begin
            state_reg    <= ASR_CONV;
            conv_cnt_reg <= '0;
          end
        end
        ASR_CONV: begin
          conv_cnt_reg <= conv_cnt_reg + 1'b1;
          if (conv_cnt_reg == 8'(CONV_CYC - 1)) begin
            state_reg <= ASR_ACQ;
          end
        end
        ASR_ACQ: begin
          if (cnv_fall) begin
            state_reg <= ASR_IDLE;
          end
        end
        default: state_reg <= ASR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_mode_reg    <= 1'b0;
      chain_busy_reg <= 1'b0;
      sample_reg     <= '0;
    end else if (state_reg == ASR_IDLE && cnv_rise) begin
      // Select level just ahead of the start edge; chain busy takes the serial clock level at start
      cs_mode_reg    <= sdi_q;
      chain_busy_reg <= sck_s2;
      sample_reg     <= sample_value;
    end
  end

  logic conv_end;
  assign conv_end = state_reg == ASR_CONV
                    && conv_cnt_reg == 8'(CONV_CYC - 1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_en_reg <= 1'b0;
      result_reg  <= '0;
      base_reg    <= '0;
    end else if (conv_end) begin
      // Busy in chip-select mode is asked for by selecting early
      busy_en_reg <= cs_mode_reg ? !sdi_s2 : chain_busy_reg;
      result_reg  <= sample_reg;
      base_reg    <= fall_now;
    end else if (state_reg == ASR_ACQ && cs_mode_reg && sdi_fall) begin
      base_reg <= fall_now;
    end
  end

  // Serial output selection
  logic [CW-1:0] k_falls;
  logic [CW-1:0] pos;
  logic          data_bit;
  logic          sdo_next;
  logic          oe_next;

  assign k_falls  = fall_now - base_reg;
  assign pos      = k_falls - CW'(busy_en_reg);
  assign data_bit = result_reg[MSB_IDX - pos[3:0]];

  always_comb begin
    sdo_next = 1'b0;
    oe_next  = 1'b0;
    case (state_reg)
      ASR_IDLE: begin
        oe_next = !sdi_s2 && !cnv_s2;
      end
      ASR_CONV: begin
        if (cs_mode_reg) begin
          oe_next = !sdi_s2 && !cnv_s2;
        end else begin
          oe_next = 1'b1;
        end
      end
      ASR_ACQ: begin
        if (cs_mode_reg) begin
          // Release on the 16th fall, 17th with busy, or on deselect
          oe_next = !sdi_s2
                    && k_falls < CW'(RW + int'(busy_en_reg));
          if (busy_en_reg && k_falls == '0) begin
            sdo_next = 1'b0;
          end else begin
            sdo_next = data_bit;
          end
        end else begin
          oe_next = 1'b1;
          if (busy_en_reg && k_falls == '0) begin
            sdo_next = sdi_s2;
          end else if (pos < CW'(RW)) begin
            sdo_next = data_bit;
          end else begin
            sdo_next = chn_s2;
          end
        end
      end
      default: begin
        sdo_next = 1'b0;
        oe_next  = 1'b0;
      end
    endcase
  end

  logic sdo_reg;
  logic sdo_oe_reg;
  logic conv_busy_reg;
  logic powered_down_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sdo_reg          <= 1'b0;
      sdo_oe_reg       <= 1'b0;
      conv_busy_reg    <= 1'b0;
      powered_down_reg <= 1'b1;
    end else begin
      sdo_reg          <= sdo_next;
      sdo_oe_reg       <= oe_next;
      conv_busy_reg    <= state_reg == ASR_CONV && !conv_end;
      powered_down_reg <= state_reg != ASR_CONV || conv_end;
    end
  end

  assign link.sdo_o  = sdo_reg;
  assign link.sdo_oe = sdo_oe_reg;
  assign conv_busy   = conv_busy_reg;
  assign powered_down = powered_down_reg;
  assign result      = result_reg;

endmodule // asr_dev

`default_nettype wire

// >>> rtl/asr_host.sv
// Host end: starts conversions and reads results back.
// Assumes its clk is the only clock; it makes the serial clock itself.
`default_nettype none

module asr_host #(
  parameter int N_DEV = 1
) (
  input  wire logic                           clk,
  input  wire logic                           rstn,
  asr_link_if.hst                             link,
  input  wire logic                           start,
  input  wire logic                           chain_mode,
  input  wire logic                           busy_req,
  output logic                                ready,
  output logic                                done,
  output logic [asr_pkg::RES_W*N_DEV-1:0]     data
);

  localparam int DW = asr_pkg::RES_W * N_DEV;

  typedef enum logic [2:0] {
    AH_IDLE,
    AH_SETUP,
    AH_CONV,
    AH_WAIT,
    AH_SELECT,
    AH_SHIFT,
    AH_END
  } asr_host_state_t;

  logic sdo_s1, sdo_s2;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sdo_s1 <= 1'b1;
      sdo_s2 <= 1'b1;
    end else begin
      sdo_s1 <= link.serial_result_output;
      sdo_s2 <= sdo_s1;
    end
  end

  asr_host_state_t state_reg;
  logic [15:0]     tmr_reg;
  logic [15:0]     nbits_reg;
  logic [15:0]     bit_reg;
  logic            chain_reg, busy_reg;
  logic            cnv_reg, sck_reg, sdi_reg;
  logic            done_reg;
  logic [DW-1:0]   sr_reg;
  logic [DW-1:0]   data_reg;

  logic tmr_hit_half;
  assign tmr_hit_half = tmr_reg == 16'(asr_pkg::SCK_HALF_CYC - 1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= AH_IDLE;
      tmr_reg   <= '0;
      nbits_reg <= '0;
      bit_reg   <= '0;
      chain_reg <= 1'b0;
      busy_reg  <= 1'b0;
      cnv_reg   <= 1'b0;
      sck_reg   <= 1'b0;
      sdi_reg   <= 1'b1;
      done_reg  <= 1'b0;
      sr_reg    <= '0;
      data_reg  <= '0;
    end else begin
      done_reg <= 1'b0;
      tmr_reg  <= tmr_reg + 1'b1;
      case (state_reg)
        AH_IDLE: begin
          if (start) begin
            chain_reg <= chain_mode;
            busy_reg  <= busy_req;
            nbits_reg <= 16'((chain_mode ? DW : asr_pkg::RES_W)
                             + int'(busy_req));
            sdi_reg   <= !chain_mode;
            sck_reg   <= chain_mode && busy_req;
            tmr_reg   <= '0;
            state_reg <= AH_SETUP;
          end
        end
        AH_SETUP: begin
          if (tmr_reg == 16'(asr_pkg::QUIET_CYC)) begin
            cnv_reg   <= 1'b1;
            sdi_reg   <= !chain_reg || busy_reg;
            tmr_reg   <= '0;
            state_reg <= AH_CONV;
          end
        end
        AH_CONV: begin
          if (!chain_reg && busy_reg
              && tmr_reg == 16'(asr_pkg::SEL_DELAY_CYC)) begin
            sdi_reg <= 1'b0;
          end
          if (busy_reg && tmr_reg == 16'(asr_pkg::SEL_DELAY_CYC)) begin
            tmr_reg   <= '0;
            state_reg <= AH_WAIT;
          end else if (!busy_reg && tmr_reg == 16'(asr_pkg::CONV_MAX_CYC
                                                  + asr_pkg::SYNC_MARGIN)) begin
            tmr_reg   <= '0;
            sdi_reg   <= chain_reg ? 1'b0 : 1'b0;
            state_reg <= AH_SELECT;
          end
        end
        AH_WAIT: begin
          // Busy-enable clock level dropped early, clear of the start edge
          if (tmr_reg == 16'h0001) begin
            sck_reg <= 1'b0;
          end
          // Busy edge: low in chip-select, high in chain
          if (sdo_s2 == chain_reg
              || tmr_reg == 16'(asr_pkg::BUSY_WAIT_CYC)) begin
            tmr_reg   <= '0;
            state_reg <= AH_SELECT;
          end
        end
        AH_SELECT: begin
          if (tmr_hit_half) begin
            tmr_reg   <= '0;
            bit_reg   <= '0;
            state_reg <= AH_SHIFT;
          end
        end
        AH_SHIFT: begin
          if (tmr_hit_half) begin
            tmr_reg <= '0;
            sck_reg <= !sck_reg;
            if (sck_reg) begin
              // Sample just before the fall; busy bit leaves the top
              sr_reg  <= {sr_reg[DW-2:0], sdo_s2};
              bit_reg <= bit_reg + 1'b1;
              if (bit_reg == nbits_reg - 1'b1) begin
                state_reg <= AH_END;
              end
            end
          end
        end
        AH_END: begin
          if (tmr_hit_half) begin
            sdi_reg   <= 1'b1;
            cnv_reg   <= 1'b0;
            data_reg  <= sr_reg;
            done_reg  <= 1'b1;
            state_reg <= AH_IDLE;
          end
        end
        default: state_reg <= AH_IDLE;
      endcase
    end
  end

  logic ready_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= state_reg == AH_IDLE && !start;
    end
  end

  assign link.conversion_start = cnv_reg;
  assign link.sck = sck_reg;
  assign link.select_or_chain_input = sdi_reg;
  assign ready    = ready_reg;
  assign done     = done_reg;
  assign data     = data_reg;

endmodule // asr_host

`default_nettype wire

// >>> rtl/asr_link_if.sv
// Four-wire link between converter and host.
// Assumes a pull-up on the serial output: released means high.
`default_nettype none

interface asr_link_if;
  logic conversion_start;
  logic sck;
  logic select_or_chain_input;
  logic sdo_o;
  logic sdo_oe;
  logic serial_result_output;

  // Pull-up resolves the released output to high
  assign serial_result_output = sdo_oe ? sdo_o : 1'b1;

  modport dev (
    input  conversion_start,
    input  sck,
    input  select_or_chain_input,
    output sdo_o,
    output sdo_oe
  );

  modport hst (
    output conversion_start,
    output sck,
    output select_or_chain_input,
    input  serial_result_output
  );
endinterface

`default_nettype wire

// >>> rtl/asr_pkg.sv
// Shared constants for the serial converter readout link.
// Assumes both ends run their logic clock at the rate given here.
`default_nettype none

package asr_pkg;

  localparam int RES_W         = 16;
  localparam int CLK_NS        = 40;
  // Conversion time window; plain defaults, shorten freely
  localparam int CONV_MIN_NS   = 500;
  localparam int CONV_MAX_NS   = 800;
  localparam int CONV_MIN_CYC  = (CONV_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_MAX_CYC  = CONV_MAX_NS / CLK_NS;
  // Quiet time on digital lines ahead of the sampling edge
  localparam int QUIET_NS      = 30;
  localparam int QUIET_CYC     = (QUIET_NS + CLK_NS - 1) / CLK_NS;
  // Busy request placed early in the first quarter of conversion
  localparam int SEL_DELAY_CYC = 2;
  // Synchroniser and output flop slack seen across the link
  localparam int SYNC_MARGIN   = 4;
  localparam int SCK_HALF_CYC  = 8;
  localparam int BUSY_WAIT_CYC = 2 * CONV_MAX_CYC + SYNC_MARGIN;
  localparam int CNT_W         = 12;

  function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b = '0;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [CNT_W-1:0] bin2gray(input logic [CNT_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

endpackage

`default_nettype wire

// >>> verif/adc_serial_readout_modes_tb.sv
// Bench joining host and converter ends over the link interface.
// Assumes one 25 MHz clock for both ends; the host makes the serial clock.
`default_nettype none

module adc_serial_readout_modes_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        rstn;
  logic        start;
  logic        chain_mode;
  logic        busy_req;
  logic [15:0] sample_value;
  logic        ready;
  logic        done;
  logic [15:0] data;
  logic [15:0] result;
  logic        powered_down;
  logic [4:0]  nf = 5'h00;
  logic [15:0] sh = 16'h0000;
  int          err_total = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [15:0] vals [8] = '{16'hA5C3, 16'h8001, 16'h7FFE, 16'h3C5A,
                            16'hFFFF, 16'h0000, 16'h1234, 16'hE1B7};

  asr_link_if asr_link_if_i ();

  asr_dev #(.CONV_CYC(20)) asr_dev_i (
    .clk          (clk),
    .rstn         (rstn),
    .link         (asr_link_if_i),
    .sample_value (sample_value),
    .conv_busy    (),
    .powered_down (powered_down),
    .result       (result)
  );

  asr_host #(.N_DEV(1)) asr_host_i (
    .clk        (clk),
    .rstn       (rstn),
    .link       (asr_link_if_i),
    .start      (start),
    .chain_mode (chain_mode),
    .busy_req   (busy_req),
    .ready      (ready),
    .done       (done),
    .data       (data)
  );

  asr_link_asserts asr_link_asserts_i (
    .clk    (clk),
    .rstn   (rstn),
    .conversion_start    (asr_link_if_i.conversion_start),
    .sck    (asr_link_if_i.sck),
    .select_or_chain_input    (asr_link_if_i.select_or_chain_input),
    .sdo_o  (asr_link_if_i.sdo_o),
    .sdo_oe (asr_link_if_i.sdo_oe),
    .serial_result_output    (asr_link_if_i.serial_result_output)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Wire monitor: count readback falls and capture the resolved line at each one
  always @(posedge asr_link_if_i.conversion_start) begin
    nf = 5'h00;
    sh = 16'h0000;
  end

  always @(negedge asr_link_if_i.sck) begin
    // Only readback falls count; set-up falls happen while converting
    if (asr_link_if_i.conversion_start === 1'b1 && powered_down === 1'b1) begin
      nf = nf + 5'h01;
      sh = {sh[14:0], asr_link_if_i.serial_result_output};
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic run(input logic cm, input logic br, input logic [15:0] v);
    int         n;
    logic [4:0] exp_nf;
    n = 0;
    exp_nf = br ? 5'h11 : 5'h10;
    @(posedge clk);
    sample_value <= v;
    chain_mode <= cm;
    busy_req <= br;
    @(negedge clk);
    while (ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(data, v, "host data");
    chk(result, v, "device result");
    chk({15'h0000, powered_down}, 16'h0001, "power down");
    chk({11'h000, nf}, {11'h000, exp_nf}, "clock falls");
    chk(sh, v, "wire bits");
    $display("test chain %0d busy %0d value %h done", cm, br, v);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      $display("MISMATCH t=%0t run did not finish", $time);
      finish_test();
    end
  end

  initial begin
    rstn = 1'b0;
    start = 1'b0;
    chain_mode = 1'b0;
    busy_req = 1'b0;
    sample_value = 16'h0000;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    // Every mode twice, all four in turn and then again, with boundary values
    for (int k = 0; k < 8; k++) begin
      run(k[1], k[0], vals[k]);
    end
    finish_test();
  end
endmodule // adc_serial_readout_modes_tb

`default_nettype wire

// >>> verif/asr_link_asserts.sv
// Checker for the converter readout link, fed the interface signals.
// Assumes both ends share clk and rstn; no bind, instantiated in the bench.
`default_nettype none

module asr_link_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic conversion_start,
  input wire logic sck,
  input wire logic select_or_chain_input,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic serial_result_output
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       cnv_q;
  logic       sdi_q;
  logic       sck_q;
  logic       cs_q;
  logic [4:0] nfall;
  logic [5:0] since;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnv_q <= 1'b0;
      sdi_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      cnv_q <= conversion_start;
      sdi_q <= select_or_chain_input;
      sck_q <= sck;
    end
  end

  // Select level just ahead of the start edge picks the mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cs_q <= 1'b0;
    else if (conversion_start && !cnv_q) cs_q <= sdi_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) nfall <= 5'h00;
    // Falls inside the conversion are mode set-up, not readback
    else if (!conversion_start || since < 6'h14) nfall <= 5'h00;
    else if (sck_q && !sck && nfall != 5'h1F) nfall <= nfall + 5'h01;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) since <= 6'h00;
    else if (conversion_start && !cnv_q) since <= 6'h00;
    else if (since != 6'h3F) since <= since + 6'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_cs_start_release: assert property (
    $rose(conversion_start) && $past(select_or_chain_input) |-> ##[1:6] !sdo_oe)
    else $error("output not released after chip-select start");
  a_idle_drive_low: assert property (
    (!conversion_start && !select_or_chain_input) [*8] |-> sdo_oe && !sdo_o)
    else $error("output not driven low with start and select low");
  a_desel_release: assert property (
    cs_q && select_or_chain_input [*6] |-> !sdo_oe)
    else $error("output driven while deselected");
  a_release_after_17: assert property (
    cs_q && nfall == 5'h11 |-> ##[0:6] !sdo_oe)
    else $error("output not released after 17th fall");
  a_stable_on_rise: assert property (
    conversion_start && $rose(sck) |-> $stable(serial_result_output))
    else $error("serial output moved at a rising clock");
  a_quiet_start: assert property (
    $rose(conversion_start) |-> $stable(sck) ##1 $stable(sck))
    else $error("serial clock moved at conversion start");
  a_fall_count: assert property (
    $fell(conversion_start) |-> nfall inside {5'h10, 5'h11})
    else $error("wrong number of clock falls in session");
  a_chain_out: assert property (
    !cs_q && conversion_start && since == 6'h1E |-> sdo_oe)
    else $error("chain output not driven after conversion");
endmodule // asr_link_asserts

`default_nettype wire
